/* File: logic/sirl_consts.svh */
// Register indices, field positions, reset values and counts of the system integration unit.
`ifndef SIRL_CONSTS_SVH
`define SIRL_CONSTS_SVH
`define SIRL_IDX_BRK     16'hfe00
`define SIRL_IDX_RSTC    16'hfe01
`define SIRL_IDX_BFC     16'hfe03
`define SIRL_IDX_PEND_B  16'hfe04
`define SIRL_IDX_PEND_C  16'hfe05
`define SIRL_IDX_PEND_D  16'hfe06
`define SIRL_IDX_CFG     16'hfe07
`define SIRL_BIT_BEW     1
`define SIRL_BIT_BREAK_CLEAR_ENABLE    7
`define SIRL_BIT_WDIS    0
`define SIRL_BIT_SHORT_STOP_RECOVERY   1
`define SIRL_BIT_POR     7
`define SIRL_BIT_PIN     6
`define SIRL_BIT_WDOG    5
`define SIRL_BIT_BADOP   4
`define SIRL_BIT_BADAD   3
`define SIRL_BIT_MON     2
`define SIRL_BIT_LOWV    1
`define SIRL_RC_RESET    8'h80
`define SIRL_STOP_LONG   13'd4096
`define SIRL_STOP_SHORT  13'd32
`define SIRL_RST_SMP     13'd32
`define SIRL_RST_DRV     13'd32
`endif

/* File: logic/sirl_pkg.sv */
// Types of the system integration unit.
`default_nettype none
package sirl_pkg;
   typedef enum logic [5:0] {
      SIRL_RUN   = 6'b000001,
      SIRL_WAIT  = 6'b000010,
      SIRL_STOP  = 6'b000100,
      SIRL_RECOV = 6'b001000,
      SIRL_RDRV  = 6'b010000,
      SIRL_RSMP  = 6'b100000
   } sirl_st_t;
   typedef struct packed {
      sirl_st_t    st;
      logic [12:0] cnt;
      logic        pin1, pin2, irq1, irq2;
      logic [7:0]  rcause;
      logic        bew, break_clear_enable, wdis, short_stop_recovery, in_brk;
      logic [24:1] pend;
      logic        wreq;
      logic [7:0]  rdata;
      logic        cpu_rst, pin_oe, cpu_ck, per_ck, osc_ck;
      logic        clr_i, stack, software_interrupt, irq_out, clr_ok, wdog_en;
   } sirl_state_t;
endpackage : sirl_pkg
`default_nettype wire

/* File: logic/sirl_top.sv */
// System integration unit: reset cause, break, wait and stop sequencing, pending status.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "sirl_consts.svh"
// Behaviour
// - Pending flags mirror each source request.
// - Top status register upper six bits zero.
// - Resets equal, above every interrupt.
// - Break forces software interrupt vector.
// - Break blocks flag clears unless enabled.
// - Flags cleared in break stay cleared.
// - Two-step clears protected, resume after break.
// - Wait or stop clears interrupt mask.
// - Wait gates processor clocks, peripherals run.
// - Wait wake stacks one cycle later.
// - Reset or break ends wait; break flagged.
// - Watchdog stays enabled unless disabled.
// - Stop clears counter, stops clocks; irq/reset exit.
// - Recovery 4096 cycles, or 32 if short.
// - Counter held in stop, times recovery.
// - Stop wake stacks after full recovery.
// - Power-on sets its flag; read clears all.
// - Drive pin low; sample 32 after release.
// - Separate cause flags per reset source.
// - Address flag only for opcode fetches.
// - Monitor flag on blank vector, irq high.
// - Mask blocks all but software interrupt.
module sirl_top (
   // Clock and synchronous reset.
   input  wire logic        clock,
   input  wire logic        rst,
   // Avalon-MM register slave.
   input  wire logic [17:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Interrupt sources and processor handshake.
   input  wire logic [24:1] irq_src,
   input  wire logic        cpu_i_mask,
   input  wire logic        wait_exec,
   input  wire logic        stop_exec,
   input  wire logic        break_req,
   input  wire logic        break_done,
   output logic             irq_to_cpu,
   output logic             stack_start,
   output logic             force_swi,
   output logic             clear_i_mask,
   output logic             in_break,
   output logic             flag_clear_ok,
   // Reset sources.
   input  wire logic        wdog_timeout,
   input  wire logic        bad_opcode,
   input  wire logic        bad_address,
   input  wire logic        opcode_fetch,
   input  wire logic        low_voltage,
   input  wire logic        monitor_entry,
   input  wire logic [7:0]  vec_hi,
   input  wire logic [7:0]  vec_lo,
   input  wire logic        irq_pin,
   // Open-drain reset pin.
   input  wire logic        rst_pin_i,
   output logic             rst_pin_o,
   output logic             rst_pin_oe,
   // Clock gating and reset to the rest of the chip.
   output logic             cpu_clk_en,
   output logic             periph_clk_en,
   output logic             osc_clk_en,
   output logic             cpu_reset,
   output logic             wdog_enable
);
   import sirl_pkg::*;

   sirl_state_t s_r;
   sirl_state_t s_nxt;
   logic [15:0] idx;
   logic        go;
   logic        wr_ok;
   logic        rd_done;
   logic        rst_evt;
   logic [7:0]  set_rc;
   logic [12:0] rec_lim;

   // Turns a byte address into the register index.
   function automatic logic [15:0] reg_idx(input logic [17:0] a);
      reg_idx = {14'h0000, a[17:16]} << 14 | {2'h0, a[15:2]};
   endfunction : reg_idx

   // Register bus decode; a request completes when waitrequest is low.
   always_comb
   begin
      idx     = reg_idx(avs_address);
      go      = (avs_read | avs_write) & ~s_r.wreq;
      wr_ok   = go & avs_write & avs_byteenable[0];
      rd_done = go & avs_read;
   end

   // Reset causes raised this cycle; any one starts an internal reset.
   always_comb
   begin
      set_rc = 8'h00;
      set_rc[`SIRL_BIT_WDOG]  = wdog_timeout;
      set_rc[`SIRL_BIT_BADOP] = bad_opcode;
      set_rc[`SIRL_BIT_BADAD] = bad_address & opcode_fetch;
      set_rc[`SIRL_BIT_LOWV]  = low_voltage;
      set_rc[`SIRL_BIT_MON]   = monitor_entry & (vec_hi == 8'hff)
                                & (vec_lo == 8'hff) & s_r.irq2;
      rst_evt = |set_rc;
      rec_lim = s_r.short_stop_recovery ? `SIRL_STOP_SHORT : `SIRL_STOP_LONG;
   end

   // Next state of the whole unit.
   always_comb
   begin
      s_nxt       = s_r;
      s_nxt.pin1  = rst_pin_i;
      s_nxt.pin2  = s_r.pin1;
      s_nxt.irq1  = irq_pin;
      s_nxt.irq2  = s_r.irq1;
      s_nxt.pend  = irq_src;
      s_nxt.stack = 1'b0;
      s_nxt.software_interrupt   = 1'b0;
      s_nxt.clr_i = 1'b0;
      s_nxt.wreq  = ~((avs_read | avs_write) & s_r.wreq);
      s_nxt.cnt   = s_r.cnt + 13'd1;

      // Read data is latched in the wait cycle and held while waitrequest is low.
      if ((avs_read | avs_write) & s_r.wreq)
      begin
         case (idx)
            `SIRL_IDX_BRK:    s_nxt.rdata = {6'h00, s_r.bew, 1'b0};
            `SIRL_IDX_RSTC:   s_nxt.rdata = s_r.rcause;
            `SIRL_IDX_BFC:    s_nxt.rdata = {s_r.break_clear_enable, 7'h00};
            `SIRL_IDX_PEND_B: s_nxt.rdata = s_r.pend[14:7];
            `SIRL_IDX_PEND_C: s_nxt.rdata = s_r.pend[22:15];
            `SIRL_IDX_PEND_D: s_nxt.rdata = {6'h00, s_r.pend[24:23]};
            `SIRL_IDX_CFG:    s_nxt.rdata = {6'h00, s_r.short_stop_recovery, s_r.wdis};
            default:          s_nxt.rdata = 8'h00;
         endcase
      end

      // Register writes; the break flag clears on writing zero.
      if (wr_ok)
      begin
         case (idx)
            `SIRL_IDX_BRK: s_nxt.bew  = s_r.bew & avs_writedata[`SIRL_BIT_BEW];
            `SIRL_IDX_BFC: s_nxt.break_clear_enable = avs_writedata[`SIRL_BIT_BREAK_CLEAR_ENABLE];
            `SIRL_IDX_CFG:
            begin
               s_nxt.wdis  = avs_writedata[`SIRL_BIT_WDIS];
               s_nxt.short_stop_recovery = avs_writedata[`SIRL_BIT_SHORT_STOP_RECOVERY];
            end
            default: s_nxt.rcause = s_nxt.rcause;
         endcase
      end

      // Reading the cause register clears it; a new cause in the same cycle wins.
      if (rd_done && idx == `SIRL_IDX_RSTC)
         s_nxt.rcause = 8'h00;
      s_nxt.rcause = s_nxt.rcause | set_rc;

      // Break entry and exit.
      if (break_done)
         s_nxt.in_brk = 1'b0;
      if (break_req && !s_r.in_brk && !s_r.cpu_rst)
      begin
         s_nxt.in_brk = 1'b1;
         s_nxt.software_interrupt    = 1'b1;
      end

      // Power and reset sequencing.
      case (s_r.st)
         SIRL_RUN:
         begin
            s_nxt.cnt = 13'd0;
            if (wait_exec)
            begin
               s_nxt.st    = SIRL_WAIT;
               s_nxt.clr_i = 1'b1;
            end
            else if (stop_exec)
            begin
               s_nxt.st    = SIRL_STOP;
               s_nxt.clr_i = 1'b1;
            end
         end
         SIRL_WAIT:
         begin
            s_nxt.cnt = 13'd0;
            if (break_req)
            begin
               s_nxt.st  = SIRL_RUN;
               s_nxt.bew = 1'b1;
            end
            else if ((|irq_src) && !cpu_i_mask)
            begin
               s_nxt.st    = SIRL_RUN;
               s_nxt.stack = 1'b1;
            end
         end
         SIRL_STOP:
         begin
            s_nxt.cnt = 13'd0;
            if (|irq_src)
               s_nxt.st = SIRL_RECOV;
         end
         SIRL_RECOV:
         begin
            if (s_r.cnt == rec_lim - 13'd1)
            begin
               s_nxt.st    = SIRL_RUN;
               s_nxt.stack = 1'b1;
            end
         end
         SIRL_RDRV:
         begin
            if (s_r.cnt == `SIRL_RST_DRV - 13'd1)
            begin
               s_nxt.st  = SIRL_RSMP;
               s_nxt.cnt = 13'd0;
            end
         end
         SIRL_RSMP:
         begin
            if (s_r.cnt == `SIRL_RST_SMP - 13'd1)
            begin
               s_nxt.st = SIRL_RUN;
               if (!s_r.pin2)
                  s_nxt.rcause[`SIRL_BIT_PIN] = 1'b1;
            end
         end
         default: s_nxt.st = SIRL_RUN;
      endcase

      // Any internal reset cause ends every mode and drives the pin, ahead of interrupts.
      if (rst_evt && s_r.st != SIRL_RDRV)
      begin
         s_nxt.st  = SIRL_RDRV;
         s_nxt.cnt = 13'd0;
      end
      else if (!s_r.pin2 && !s_r.pin_oe && !s_r.cpu_rst)
      begin
         s_nxt.st  = SIRL_RSMP;
         s_nxt.cnt = 13'd0;
      end

      // Outputs follow the next state, clr_ok and wdog_en the current one, so that each comes from a flip-flop.
      s_nxt.cpu_rst = s_nxt.st == SIRL_RDRV || s_nxt.st == SIRL_RSMP;
      s_nxt.pin_oe  = s_nxt.st == SIRL_RDRV;
      s_nxt.cpu_ck  = s_nxt.st == SIRL_RUN || s_nxt.cpu_rst;
      s_nxt.per_ck  = s_nxt.st != SIRL_STOP && s_nxt.st != SIRL_RECOV;
      s_nxt.osc_ck  = s_nxt.st != SIRL_STOP;
      s_nxt.irq_out = (|irq_src) && !cpu_i_mask && !s_nxt.cpu_rst;
      s_nxt.clr_ok  = !(s_r.in_brk && !s_r.break_clear_enable);
      s_nxt.wdog_en = !s_r.wdis;
      if (s_nxt.cpu_rst)
      begin
         s_nxt.stack  = 1'b0;
         s_nxt.software_interrupt    = 1'b0;
         s_nxt.in_brk = 1'b0;
      end

      // Power-on reset sets only its own flag.
      if (rst)
      begin
         s_nxt         = '0;
         s_nxt.st      = SIRL_RUN;
         s_nxt.rcause  = `SIRL_RC_RESET;
         s_nxt.wreq    = 1'b1;
         s_nxt.pin1    = 1'b1;
         s_nxt.pin2    = 1'b1;
         s_nxt.cpu_ck  = 1'b1;
         s_nxt.per_ck  = 1'b1;
         s_nxt.osc_ck  = 1'b1;
         s_nxt.clr_ok  = 1'b1;
         s_nxt.wdog_en = 1'b1;
      end
   end

   // The single state register.
   always_ff @(posedge clock)
   begin
      s_r <= s_nxt;
   end

   // Ports taken straight from the state register, except the pin output, which is tied low.
   assign avs_readdata    = {24'h000000, s_r.rdata};
   assign avs_waitrequest = s_r.wreq;
   assign irq_to_cpu      = s_r.irq_out;
   assign stack_start     = s_r.stack;
   assign force_swi       = s_r.software_interrupt;
   assign clear_i_mask    = s_r.clr_i;
   assign in_break        = s_r.in_brk;
   assign flag_clear_ok   = s_r.clr_ok;
   assign rst_pin_o       = 1'b0;
   assign rst_pin_oe      = s_r.pin_oe;
   assign cpu_clk_en      = s_r.cpu_ck;
   assign periph_clk_en   = s_r.per_ck;
   assign osc_clk_en      = s_r.osc_ck;
   assign cpu_reset       = s_r.cpu_rst;
   assign wdog_enable     = s_r.wdog_en;

   // Checks on the sequencing.
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence seq_wait_wake;
      s_r.st == SIRL_WAIT && (|irq_src) && !cpu_i_mask && !break_req && !rst_evt && s_r.pin2;
   endsequence

   sequence seq_rc_read;
      rd_done && idx == `SIRL_IDX_RSTC && !rst_evt && s_r.st == SIRL_RUN && s_r.pin2;
   endsequence

   AST_PEND_MIRROR: assert property (##1 s_r.pend == $past(irq_src))
      else $error("Pending flags do not follow sources.");
   AST_TOP_ZERO: assert property (rd_done && idx == `SIRL_IDX_PEND_D |-> avs_readdata[7:2] == 6'h00)
      else $error("Upper bits of top status register not zero.");
   AST_RST_PRIO: assert property (rst_evt |=> cpu_reset && !irq_to_cpu && !stack_start)
      else $error("Reset did not take priority.");
   AST_BRK_SWI: assert property (break_req && !in_break && !cpu_reset && !rst_evt && s_r.pin2
                                 |=> force_swi && in_break)
      else $error("Break did not force the software vector.");
   AST_BRK_PROT: assert property (in_break && !s_r.break_clear_enable |=> !flag_clear_ok)
      else $error("Flag clears allowed during protected break.");
   AST_LOWPWR_I: assert property ((wait_exec || stop_exec) && s_r.st == SIRL_RUN && !rst_evt
                                  |=> clear_i_mask)
      else $error("Low-power entry did not clear the mask.");
   AST_WAIT_CLK: assert property (s_r.st == SIRL_WAIT |-> !cpu_clk_en && periph_clk_en)
      else $error("Wait mode clock gating wrong.");
   AST_WAIT_WAKE: assert property (seq_wait_wake |=> stack_start && s_r.st == SIRL_RUN)
      else $error("Wait wake did not stack one cycle later.");
   AST_STOP_CLK: assert property (s_r.st == SIRL_STOP
                                  |-> !osc_clk_en && !periph_clk_en && s_r.cnt == 13'd0)
      else $error("Stop mode clocks or counter wrong.");
   AST_REC_SHORT: assert property (s_r.st == SIRL_RECOV && s_r.short_stop_recovery
                                   && s_r.cnt == (`SIRL_STOP_SHORT - 13'd1) && !rst_evt |=> stack_start)
      else $error("Short recovery not 32 cycles.");
   AST_REC_HOLD: assert property (s_r.st == SIRL_RECOV |-> !stack_start)
      else $error("Stacking before recovery elapsed.");
   AST_RC_CLEAR: assert property (seq_rc_read |=> s_r.rcause == 8'h00)
      else $error("Cause register not cleared by read.");
endmodule : sirl_top
`default_nettype wire

/* File: verif/sirl_cpu_model.sv */
// Behavioural processor and peripheral partner of the system integration unit.
`timescale 1ns/1ns
`default_nettype none
module sirl_cpu_model (
   // Clock and reset.
   input  wire logic clock,
   input  wire logic rst,
   // Processor handshake.
   input  wire logic clear_i_mask,
   input  wire logic stack_start,
   output logic      cpu_i_mask,
   // Peripheral status flag.
   input  wire logic flag_set,
   input  wire logic flag_clr,
   input  wire logic flag_clear_ok,
   output logic      flag
);
   // The mask is set by reset and interrupt entry, lowered by the low-power entry pulse.
   always_ff @(posedge clock)
   begin
      if (rst || stack_start)
         cpu_i_mask <= 1'b1;
      else if (clear_i_mask)
         cpu_i_mask <= 1'b0;
   end
   // A clear only lands while clearing is allowed, and a set wins over a clear.
   always_ff @(posedge clock)
   begin
      if (rst)
         flag <= 1'b0;
      else if (flag_set)
         flag <= 1'b1;
      else if (flag_clr && flag_clear_ok)
         flag <= 1'b0;
   end
endmodule : sirl_cpu_model
`default_nettype wire

/* File: verif/system_integration_reset_lowpower_test.sv */
// Self-checking bench of the system integration unit.
`timescale 1ns/1ns
`default_nettype none
`include "sirl_consts.svh"
module system_integration_reset_lowpower_test;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic [17:0] avs_address = '0;
   logic        avs_read = 1'b0, avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [3:0]  avs_byteenable = 4'h1;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [24:1] bench_irq = '0;
   logic        wait_exec = 1'b0, stop_exec = 1'b0, break_req = 1'b0, break_done = 1'b0;
   logic        cpu_i_mask, irq_to_cpu, stack_start, force_swi, clear_i_mask, in_break, flag_clear_ok;
   logic [5:0]  cause_src = '0;
   logic [7:0]  vec_hi = 8'h00, vec_lo = 8'h00;
   logic        irq_pin = 1'b1, ext_low = 1'b0;
   logic        rst_pin_o, rst_pin_oe, cpu_clk_en, periph_clk_en, osc_clk_en, cpu_reset, wdog_enable;
   logic        flag, flag_set = 1'b0, flag_clr = 1'b0;
   int          n_errors = 0, samples_checked = 0, cyc = 0;
   // Reset causes come from one vector, bit 5 being a data access to a bad address; the pin has a pull-up.
   wire logic        wdog_timeout = cause_src[0], bad_opcode = cause_src[1], bad_address = cause_src[2] | cause_src[5];
   wire logic        opcode_fetch = cause_src[2], low_voltage = cause_src[3], monitor_entry = cause_src[4];
   wire logic        rst_pin_lvl = !(rst_pin_oe && !rst_pin_o) && !ext_low;
   wire logic [24:1] irq_src = bench_irq | {23'h0, flag};

   sirl_top u_dut (
      .clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq_src(irq_src), .cpu_i_mask(cpu_i_mask), .wait_exec(wait_exec),
      .stop_exec(stop_exec), .break_req(break_req), .break_done(break_done), .irq_to_cpu(irq_to_cpu),
      .stack_start(stack_start), .force_swi(force_swi), .clear_i_mask(clear_i_mask), .in_break(in_break),
      .flag_clear_ok(flag_clear_ok), .wdog_timeout(wdog_timeout), .bad_opcode(bad_opcode),
      .bad_address(bad_address), .opcode_fetch(opcode_fetch), .low_voltage(low_voltage),
      .monitor_entry(monitor_entry), .vec_hi(vec_hi), .vec_lo(vec_lo), .irq_pin(irq_pin),
      .rst_pin_i(rst_pin_lvl), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .cpu_clk_en(cpu_clk_en),
      .periph_clk_en(periph_clk_en), .osc_clk_en(osc_clk_en), .cpu_reset(cpu_reset), .wdog_enable(wdog_enable)
   );
   sirl_cpu_model u_cpu (
      .clock(clock), .rst(rst), .clear_i_mask(clear_i_mask), .stack_start(stack_start), .cpu_i_mask(cpu_i_mask),
      .flag_set(flag_set), .flag_clr(flag_clr), .flag_clear_ok(flag_clear_ok), .flag(flag)
   );

   // Clock and cycle ceiling.
   always #4 clock = ~clock;
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: timeout", $time);
         report_and_stop;
      end
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp);
      chk8({7'h0, got}, {7'h0, exp});
   endtask : chk1

   // One register access; the request stands until waitrequest is seen low.
   task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd, output logic [7:0] rd);
      @(posedge clock);
      avs_address   <= {idx, 2'b00};
      avs_writedata <= {24'h0, wd};
      avs_read      <= !wr;
      avs_write     <= wr;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata[7:0];
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
      logic [7:0] d;
      bus(1'b0, idx, 8'h00, d);
      chk8(d, exp);
   endtask : rdc

   task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
      logic [7:0] d;
      bus(1'b1, idx, wd, d);
   endtask : wr

   task automatic pend_case(input logic [24:1] p);
      @(posedge clock);
      bench_irq <= p;
      wr(`SIRL_IDX_PEND_D, 8'hff);
      rdc(`SIRL_IDX_PEND_B, p[14:7]);
      rdc(`SIRL_IDX_PEND_C, p[22:15]);
      rdc(`SIRL_IDX_PEND_D, {6'h0, p[24:23]});
      chk1(irq_to_cpu, 1'b0);
      bench_irq <= '0;
   endtask : pend_case

   // Pulses the given causes, optionally holds the pin low from outside, then reads the cause.
   task automatic rst_case(input logic [5:0] src, input logic ext, input logic [7:0] exp);
      @(posedge clock);
      cause_src <= src;
      ext_low   <= ext;
      vec_hi    <= {8{src[4]}};
      vec_lo    <= {8{src[4]}};
      @(posedge clock);
      cause_src <= '0;
      do @(posedge clock); while (cpu_reset !== 1'b1);
      chk1(rst_pin_oe, 1'b1);
      chk1(rst_pin_o, 1'b0);
      repeat (80) @(posedge clock);
      ext_low <= 1'b0;
      do @(posedge clock); while (cpu_reset !== 1'b0 || rst_pin_oe !== 1'b0);
      repeat (80) @(posedge clock);
      rdc(`SIRL_IDX_RSTC, exp);
   endtask : rst_case

   // A bad address on a data access must neither reset nor leave a cause behind.
   task automatic data_addr_case;
      @(posedge clock);
      cause_src <= 6'h20;
      @(posedge clock);
      cause_src <= '0;
      repeat (3) @(posedge clock);
      chk1(cpu_reset, 1'b0);
      rdc(`SIRL_IDX_RSTC, 8'h00);
   endtask : data_addr_case

   task automatic enter(input logic stop);
      @(posedge clock);
      wait_exec <= !stop;
      stop_exec <= stop;
      @(posedge clock);
      wait_exec <= 1'b0;
      stop_exec <= 1'b0;
      repeat (3) @(posedge clock);
      chk1(cpu_i_mask, 1'b0);
      chk1(cpu_clk_en, 1'b0);
      chk1(periph_clk_en, !stop);
   endtask : enter

   // Raises a request and counts cycles until stacking begins.
   task automatic wake(input int lo, input int hi);
      int n;
      n = 0;
      bench_irq[5] <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (stack_start !== 1'b1);
      bench_irq[5] <= 1'b0;
      chk1(irq_to_cpu, 1'b1);
      chk1(n >= lo && n <= hi, 1'b1);
   endtask : wake

   task automatic brk(input logic done);
      @(posedge clock);
      break_req  <= !done;
      break_done <= done;
      @(posedge clock);
      break_req  <= 1'b0;
      break_done <= 1'b0;
      if (!done)
         do @(posedge clock); while (force_swi !== 1'b1);
      repeat (3) @(posedge clock);
      chk1(in_break, !done);
   endtask : brk

   task automatic flag_op(input logic set, input logic exp);
      @(posedge clock);
      flag_set <= set;
      flag_clr <= !set;
      @(posedge clock);
      flag_set <= 1'b0;
      flag_clr <= 1'b0;
      repeat (2) @(posedge clock);
      chk1(flag, exp);
   endtask : flag_op

   task automatic report_and_stop;
      $display("errors %0d comparisons %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop

   // Main sequence.
   initial
   begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      rdc(`SIRL_IDX_RSTC, 8'h80);
      rdc(`SIRL_IDX_RSTC, 8'h00);
      rdc(16'hfe02, 8'h00);
      pend_case(24'hd5a5a4);
      pend_case(24'h2a5a5a);
      rst_case(6'h01, 1'b0, 8'h20);
      rst_case(6'h02, 1'b0, 8'h10);
      rst_case(6'h04, 1'b0, 8'h08);
      rst_case(6'h08, 1'b0, 8'h02);
      rst_case(6'h10, 1'b0, 8'h04);
      rst_case(6'h01, 1'b1, 8'h60);
      rst_case(6'h03, 1'b0, 8'h30);
      data_addr_case;
      flag_op(1'b1, 1'b1);
      brk(1'b0);
      chk1(flag_clear_ok, 1'b0);
      flag_op(1'b0, 1'b1);
      wr(`SIRL_IDX_BFC, 8'h80);
      rdc(`SIRL_IDX_BFC, 8'h80);
      flag_op(1'b0, 1'b0);
      wr(`SIRL_IDX_BFC, 8'h00);
      brk(1'b1);
      chk1(flag, 1'b0);
      // The first step of the two-step clear is taken before break.
      flag_op(1'b1, 1'b1);
      brk(1'b0);
      flag_op(1'b0, 1'b1);
      brk(1'b1);
      flag_op(1'b0, 1'b0);
      enter(1'b0);
      chk1(wdog_enable, 1'b1);
      // One edge to see the request in wait, one to see the stacking pulse.
      wake(2, 2);
      enter(1'b0);
      brk(1'b0);
      rdc(`SIRL_IDX_BRK, 8'h02);
      wr(`SIRL_IDX_BRK, 8'h00);
      rdc(`SIRL_IDX_BRK, 8'h00);
      brk(1'b1);
      wr(`SIRL_IDX_CFG, 8'h03);
      enter(1'b1);
      chk1(osc_clk_en, 1'b0);
      chk1(wdog_enable, 1'b0);
      // One edge to leave stop, the recovery count, one edge to see the stacking pulse.
      wake(`SIRL_STOP_SHORT + 2, `SIRL_STOP_SHORT + 2);
      wr(`SIRL_IDX_CFG, 8'h00);
      enter(1'b1);
      wake(`SIRL_STOP_LONG + 2, `SIRL_STOP_LONG + 2);
      enter(1'b0);
      rst_case(6'h01, 1'b0, 8'h20);
      enter(1'b1);
      rst_case(6'h08, 1'b0, 8'h02);
      report_and_stop;
   end
endmodule : system_integration_reset_lowpower_test
`default_nettype wire
